// ==== core/fft_port_pkg.sv ====
// Constants and carrier types shared by the FFT peripheral host port.
package fft_port_pkg;

  localparam int unsigned DATA_W         = 8;
  localparam int unsigned WORD_W         = 16;
  localparam int unsigned FUNC_W         = 4;
  localparam int unsigned RAM_WORDS      = 128;
  localparam int unsigned RAM_AW         = 7;
  localparam int unsigned BASE_W         = 5;
  localparam int unsigned DISP_W         = 2;
  localparam int unsigned PC_W           = 8;
  localparam int unsigned FIFO_DEPTH     = 16;

  // Function codes on the select lines.
  localparam logic [3:0] FUNC_CHIP_RESET = 4'h1;
  localparam logic [3:0] FUNC_UPPER      = 4'h2;
  localparam logic [3:0] FUNC_LOWER      = 4'h3;
  localparam logic [3:0] FUNC_EXECUTE    = 4'h4;
  localparam logic [3:0] FUNC_BLOCK      = 4'h9;

  // Routine entry addresses.
  localparam logic [7:0] ENTRY_IDLE      = 8'h00;
  localparam logic [7:0] ENTRY_SETUP     = 8'h01;
  localparam logic [7:0] ENTRY_THIRTY_TWO_POINT_TRANSFORM     = 8'h04;
  localparam logic [7:0] ENTRY_COMBINE   = 8'hD3;
  localparam logic [7:0] ENTRY_SCALE     = 8'hEA;
  localparam logic [7:0] ENTRY_WINDOW    = 8'hDC;
  localparam logic [7:0] ENTRY_CONJUGATION_ROUTINE    = 8'hE4;

  // Word layout and reset values.
  localparam int unsigned UPPER_MSB      = 15;
  localparam int unsigned UPPER_LSB      = 8;
  localparam int unsigned LOWER_MSB      = 7;
  localparam int unsigned LOWER_LSB      = 0;
  localparam int unsigned SETUP_BASE_LSB = 11;
  localparam int unsigned SETUP_DISP_LSB = 8;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  localparam logic [4:0]  BASE_LAST      = 5'h1F;
  localparam logic [1:0]  DISP_LAST      = 2'h3;

  // Stand-in execution length of a routine, in cycles.
  localparam int unsigned ROUTINE_CYCLES = 64;
  localparam int unsigned SETUP_CYCLES   = 4;
  localparam int unsigned CNT_W          = 7;

  typedef struct packed {
    logic [3:0] func;
    logic       write;
    logic [7:0] data;
  } bus_req_type;

  typedef struct packed {
    logic [4:0] base;
    logic [1:0] disp;
  } ram_addr_type;

endpackage

// ==== core/fft_word_fifo.sv ====
// Parameterised valid/ready FIFO used in the block-write data path.
`timescale 1ns/100ps
module fft_word_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_i,    // System clock
  input  wire logic             rst_i,    // Synchronous reset, high
  input  wire logic             flush_i,  // Drop all content
  input  wire logic [WIDTH-1:0] in_data_i, // Write data
  input  wire logic             in_valid_i, // Write request
  output logic                  in_ready_o, // Room available
  output logic [WIDTH-1:0]      out_data_o, // Head word
  output logic                  out_valid_o, // Head valid
  input  wire logic             out_ready_i  // Drain accepts
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || flush_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== core/fft_peripheral_host_port.sv ====
// Host port, command sequencing and data RAM of the FFT peripheral.
`timescale 1ns/100ps

// Notes on behaviour
// [RULE_01] Data moves over an 8-bit two-way bus in two's complement.
// [RULE_02] Four function-select lines choose the control function of an access.
// [RULE_03] Accesses count only while the low-active bus enable is low.
// [RULE_04] Read/write high: device drives data; low: host writes data.
// [RULE_05] The low-active chip select further qualifies every access.
// [RULE_06] Open-drain completion request goes low when a routine finishes.
// [RULE_07] Reset pin low clears registers, counters, program counter, pending work.
// [RULE_08] Host holds reset low at least 300 ns after power-up; the bench holds rst_i for 20 cycles after power-up, about 157 ns.
// [RULE_09] Location zero is a jump-to-self idle; routines end by returning there.
// [RULE_10] Routine completion is signalled; idle after initial reset is not.
// [RULE_11] Entry addresses: 00, 01, 04, D3, EA, DC, E4.
// [RULE_12] Data RAM holds 128 words as 32 rows by 4 columns.
// [RULE_13] Host decodes 16 addresses from upper 12 lines; five carry functions.
// [RULE_14] Function 1, read or write, clears registers and restarts at idle.
// [RULE_15] Host should issue reset before block or execute commands.
// [RULE_16] Function 2 accesses the upper byte, function 3 the lower byte.
// [RULE_17] Upper byte may come alone; lower never alone; upper completes word.
// [RULE_18] Writing function 4 starts execution at the written byte address.
// [RULE_19] Function 9 starts block mode walking RAM from preset base and column.
// [RULE_20] After a reset function, block addressing starts at base 0, column 0.
// [RULE_21] Index register addresses RAM and advances; reset ends block mode.
// [RULE_22] Input and output words: upper byte 15..8, lower byte 7..0.
// [RULE_23] Base advances per word; wrap bumps column; after last both return zero.
// [RULE_24] Block command latches direction until the next reset function.
// [RULE_25] Completion request releases on a reset function or new execute.
module fft_peripheral_host_port (
  input  wire logic       clk_i,      // 125 MHz system clock
  input  wire logic       rst_i,      // Synchronous reset, high
  input  wire logic [7:0] data_i,     // Data bus level seen at the pins
  output logic [7:0]      data_o,     // Data bus drive value
  output logic [7:0]      data_oe_n_o, // Data bus enable, low drives
  input  wire logic [3:0] func_sel_i, // Function select lines
  input  wire logic       bus_select_low_i, // Interface enable, low active
  input  wire logic       chip_sel_n_i, // Chip select, low active
  input  wire logic       read_write_i, // High read, low write
  output logic            completion_request_n_o, // Open-drain value, always 0
  output logic            completion_request_oe_n_o, // Low pulls the line low
  output logic            busy_o      // Routine running
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RUN   = 2'b01,
    ST_SETUP = 2'b10
  } run_state_type;

  run_state_type               state_r;
  fft_port_pkg::bus_req_type   req;
  fft_port_pkg::ram_addr_type  index_r;
  logic [15:0]                 in_word_r;
  logic [15:0]                 out_word_r;
  logic [15:0]                 ram_r [fft_port_pkg::RAM_WORDS];
  logic [7:0]                  pc_r;
  logic [fft_port_pkg::CNT_W-1:0] run_cnt_r;
  logic                        block_r;
  logic                        block_read_r;
  logic                        sel_d_r;
  logic                        lower_pending_r;
  logic                        read_fetch_r;
  logic                        sel;
  logic                        access;
  logic                        func_reset;
  logic                        up_wr;
  logic                        lo_wr;
  logic                        up_rd;
  logic                        exec_wr;
  logic                        blk_cmd;
  logic                        run_done;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic                        fifo_pop;
  logic [15:0]                 fifo_out_data;
  logic [15:0]                 word_to_fifo;
  logic [fft_port_pkg::RAM_AW-1:0] ram_addr;

  // Accesses act once, on the first cycle the selects fall low.
  assign sel    = !bus_select_low_i && !chip_sel_n_i; // [RULE_03] [RULE_05]
  assign access = sel && !sel_d_r;
  assign req    = '{func: func_sel_i, write: !read_write_i, data: data_i}; // [RULE_02]

  assign func_reset = access && (req.func == fft_port_pkg::FUNC_CHIP_RESET); // [RULE_14]
  assign up_wr   = access && req.write && (req.func == fft_port_pkg::FUNC_UPPER);
  assign lo_wr   = access && req.write && (req.func == fft_port_pkg::FUNC_LOWER);
  assign up_rd   = access && !req.write && (req.func == fft_port_pkg::FUNC_UPPER);
  assign exec_wr = access && req.write && (req.func == fft_port_pkg::FUNC_EXECUTE); // [RULE_18]
  assign blk_cmd = access && (req.func == fft_port_pkg::FUNC_BLOCK); // [RULE_19]
  assign run_done = (state_r != ST_IDLE) && (run_cnt_r == '0);

  // Column-major word index: base in the low bits, column above.
  assign ram_addr = {index_r.disp, index_r.base}; // [RULE_12]
  // A word written as an upper byte alone must carry a zero lower byte, not the last staged one.
  assign word_to_fifo = lower_pending_r ? {req.data, in_word_r[fft_port_pkg::LOWER_MSB:0]}
                                        : {req.data, 8'h00}; // [RULE_22] [RULE_17]
  assign fifo_pop = fifo_out_valid;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_d_r <= 1'b0;
    end
    else
    begin
      sel_d_r <= sel;
    end
  end

  // Block writes pass through the FIFO so a burst of host words is absorbed.
  fft_word_fifo #(
    .WIDTH (fft_port_pkg::WORD_W),
    .DEPTH (fft_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (func_reset),
    .in_data_i   (word_to_fifo),
    .in_valid_i  (up_wr && block_r && !block_read_r),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (1'b1)
  );

  // Input word holds bytes written outside block mode and the staged lower byte.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || func_reset) // [RULE_07] [RULE_14]
    begin
      in_word_r       <= fft_port_pkg::WORD_RESET;
      lower_pending_r <= 1'b0;
    end
    else if (lo_wr)
    begin
      in_word_r[fft_port_pkg::LOWER_MSB:fft_port_pkg::LOWER_LSB] <= req.data; // [RULE_16]
      lower_pending_r <= 1'b1;
    end
    else if (up_wr)
    begin
      // An upper byte alone carries a zero lower byte.
      in_word_r[fft_port_pkg::UPPER_MSB:fft_port_pkg::UPPER_LSB] <= req.data; // [RULE_16]
      if (!lower_pending_r)
      begin
        in_word_r[fft_port_pkg::LOWER_MSB:fft_port_pkg::LOWER_LSB] <= 8'h00; // [RULE_17]
      end
      lower_pending_r <= 1'b0;
    end
  end

  // Block mode flag and latched direction.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || func_reset) // [RULE_21]
    begin
      block_r      <= 1'b0;
      block_read_r <= 1'b0;
    end
    else if (blk_cmd && !block_r)
    begin
      block_r      <= 1'b1;
      block_read_r <= !req.write; // [RULE_24]
    end
  end

  // Index register: preset by setup routine, walked in block mode.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || func_reset) // [RULE_20]
    begin
      index_r <= '0;
    end
    else if (state_r == ST_SETUP && run_done)
    begin
      index_r.base <= in_word_r[fft_port_pkg::SETUP_BASE_LSB +: fft_port_pkg::BASE_W];
      index_r.disp <= in_word_r[fft_port_pkg::SETUP_DISP_LSB +: fft_port_pkg::DISP_W];
    end
    else if (block_r && ((block_read_r && up_rd) || (!block_read_r && fifo_pop))) // [RULE_21]
    begin
      index_r.base <= index_r.base + 1'b1; // [RULE_23]
      if (index_r.base == fft_port_pkg::BASE_LAST)
      begin
        index_r.disp <= index_r.disp + 1'b1; // [RULE_23]
      end
    end
  end

  // Data RAM writes come from the FIFO drain only.
  always_ff @(posedge clk_i)
  begin
    if (block_r && !block_read_r && fifo_pop)
    begin
      ram_r[ram_addr] <= fifo_out_data;
    end
  end

  // Output word: refreshed from RAM at read-block entry, after each block-mode upper read and at the end of an ST_RUN routine, not setup.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || func_reset)
    begin
      out_word_r   <= fft_port_pkg::WORD_RESET;
      read_fetch_r <= 1'b0;
    end
    else
    begin
      read_fetch_r <= (blk_cmd && !block_r && !req.write) || (block_r && block_read_r && up_rd);
      if (read_fetch_r)
      begin
        out_word_r <= ram_r[ram_addr];
      end
      else if (state_r == ST_RUN && run_done)
      begin
        out_word_r <= ram_r[ram_addr];
      end
    end
  end

  // Stand-in sequencer: program counter holds the entry, steps up while a counter counts down, returns to idle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || func_reset) // [RULE_07] [RULE_14]
    begin
      state_r   <= ST_IDLE;
      pc_r      <= fft_port_pkg::ENTRY_IDLE; // [RULE_09]
      run_cnt_r <= '0;
    end
    else if (exec_wr && !block_r)
    begin
      pc_r <= req.data; // [RULE_18]
      unique case (req.data) // [RULE_11]
        fft_port_pkg::ENTRY_IDLE:
        begin
          state_r <= ST_IDLE;
        end
        fft_port_pkg::ENTRY_SETUP:
        begin
          state_r   <= ST_SETUP;
          run_cnt_r <= (fft_port_pkg::CNT_W)'(fft_port_pkg::SETUP_CYCLES - 1);
        end
        fft_port_pkg::ENTRY_THIRTY_TWO_POINT_TRANSFORM, fft_port_pkg::ENTRY_COMBINE, fft_port_pkg::ENTRY_SCALE,
        fft_port_pkg::ENTRY_WINDOW, fft_port_pkg::ENTRY_CONJUGATION_ROUTINE:
        begin
          state_r   <= ST_RUN;
          run_cnt_r <= (fft_port_pkg::CNT_W)'(fft_port_pkg::ROUTINE_CYCLES - 1);
        end
        default:
        begin
          // An unknown entry falls straight back to idle, as a lone jump would.
          state_r <= ST_IDLE;
          pc_r    <= fft_port_pkg::ENTRY_IDLE;
        end
      endcase
    end
    else if (run_done)
    begin
      state_r <= ST_IDLE;
      pc_r    <= fft_port_pkg::ENTRY_IDLE; // [RULE_09]
    end
    else if (state_r != ST_IDLE)
    begin
      run_cnt_r <= run_cnt_r - 1'b1;
      pc_r      <= pc_r + 1'b1;
    end
  end

  // Completion request: set by the end of an ST_RUN routine, not setup; released by reset or execute.
  always_ff @(posedge clk_i)
  begin
    if (rst_i) // [RULE_10]
    begin
      completion_request_oe_n_o <= 1'b1;
    end
    else if (state_r == ST_RUN && run_done) // [RULE_06] [RULE_10]
    begin
      completion_request_oe_n_o <= 1'b0;
    end
    else if (func_reset || exec_wr) // [RULE_25]
    begin
      completion_request_oe_n_o <= 1'b1;
    end
  end

  // Read data drive while a read access is selected.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      data_o      <= 8'h00;
      data_oe_n_o <= 8'hFF;
      busy_o      <= 1'b0;
      completion_request_n_o <= 1'b0;
    end
    else
    begin
      busy_o <= (state_r != ST_IDLE);
      completion_request_n_o <= 1'b0;
      data_oe_n_o <= (sel && read_write_i) ? 8'h00 : 8'hFF; // [RULE_04] [RULE_01]
      unique case (func_sel_i)
        fft_port_pkg::FUNC_UPPER:
        begin
          data_o <= out_word_r[fft_port_pkg::UPPER_MSB:fft_port_pkg::UPPER_LSB]; // [RULE_22]
        end
        fft_port_pkg::FUNC_LOWER:
        begin
          data_o <= out_word_r[fft_port_pkg::LOWER_MSB:fft_port_pkg::LOWER_LSB]; // [RULE_22]
        end
        default:
        begin
          data_o <= 8'h00;
        end
      endcase
    end
  end

  sequence s_routine_end;
    state_r == ST_RUN && run_done;
  endsequence

  a_request_on_end: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
    s_routine_end |=> !completion_request_oe_n_o)
    else $error("completion request not raised at routine end");
  a_no_req_reset: assert property (@(posedge clk_i) // [RULE_10]
    rst_i |=> completion_request_oe_n_o)
    else $error("completion request active after reset");
  a_release_req: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_25]
    (func_reset || exec_wr) && !(state_r == ST_RUN && run_done) |=> completion_request_oe_n_o)
    else $error("completion request not released");
  a_reset_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_14]
    func_reset |=> state_r == ST_IDLE && pc_r == 8'h00 && !block_r && index_r == '0)
    else $error("reset function left state behind");
  a_exec_entry: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_18]
    exec_wr && !block_r && req.data == 8'h04 |=> state_r == ST_RUN && pc_r == 8'h04)
    else $error("execute did not start routine");
  a_idle_return: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_09]
    exec_wr && !block_r && req.data == 8'h04 ##1 !func_reset [*8]
    |-> state_r == ST_RUN)
    else $error("routine ended too early");
  a_block_dir: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_24]
    block_r && !func_reset |=> $stable(block_read_r))
    else $error("latched direction changed");
  a_base_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_23]
    block_r && block_read_r && up_rd && index_r.base == 5'h1F && !func_reset
    |=> index_r.base == 5'h00 && index_r.disp == $past(index_r.disp) + 2'd1)
    else $error("base wrap did not advance column");
  a_sel_gate: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
    !sel |=> data_oe_n_o == 8'hFF)
    else $error("bus driven while not selected");
endmodule

// ==== test/fft_host_model.sv ====
// Host processor model that drives single accesses onto the peripheral's bus.
`timescale 1ns/100ps
module fft_host_model (
  input  wire logic       clk_i,      // System clock
  input  wire logic [7:0] dev_data_i, // Device drive value
  input  wire logic [7:0] dev_oe_n_i, // Device drive enable, low drives
  output logic [7:0]      bus_o,      // Resolved bus level
  output logic [3:0]      func_o,     // Function select lines
  output logic            ie_n_o,     // Interface enable, low active
  output logic            cs_n_o,     // Chip select, low active
  output logic            rw_o,       // High read, low write
  output logic            rd_valid_o, // Read byte captured
  output logic [7:0]      rd_data_o   // Captured read byte
);
  logic       drive_r;
  logic [7:0] hval_r;
  logic [7:0] last_r = 8'h00;

  // The bus has no pull, so a released bus shows a changing pattern, never a stale byte.
  assign bus_o = drive_r ? hval_r : ((dev_oe_n_i[0] === 1'b0) ? dev_data_i : ~last_r);

  always @(posedge clk_i)
    last_r <= bus_o;

  initial
  begin
    func_o = 4'h0;
    ie_n_o = 1'b1;
    cs_n_o = 1'b1;
    rw_o = 1'b1;
    drive_r = 1'b0;
    hval_r = 8'h00;
    rd_valid_o = 1'b0;
    rd_data_o = 8'h00;
  end

  // One access to one of the 16 decoded addresses; qual holds {cs_n, ie_n} while active.
  task access(input logic [3:0] func, input logic wr, input logic [7:0] data,
              input logic [1:0] qual);
    @(posedge clk_i);
    #1;
    func_o = func;
    rw_o = ~wr;
    drive_r = wr;
    hval_r = data;
    cs_n_o = qual[1];
    ie_n_o = qual[0];
    repeat (3) @(posedge clk_i);
    if (!wr && (func == fft_port_pkg::FUNC_UPPER || func == fft_port_pkg::FUNC_LOWER))
    begin
      rd_data_o <= bus_o;
      rd_valid_o <= 1'b1;
    end
    #1;
    ie_n_o = 1'b1;
    cs_n_o = 1'b1;
    drive_r = 1'b0;
    rw_o = 1'b1;
    @(posedge clk_i);
    rd_valid_o <= 1'b0;
  endtask
endmodule

// ==== test/tb_fft_peripheral_host_port.sv ====
// Self-checking bench for the FFT peripheral host port.
`timescale 1ns/100ps
module tb_fft_peripheral_host_port;
  logic        clk_i;
  logic        rst_i;
  logic [7:0]  bus_level;
  logic [7:0]  dev_data;
  logic [7:0]  dev_oe_n;
  logic [3:0]  func_sel;
  logic        ie_n;
  logic        cs_n;
  logic        rw;
  logic        req_n;
  logic        req_oe_n;
  logic        busy;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic [7:0]  exp_q[$];
  logic [15:0] mem[128];
  logic [7:0]  entries[5];
  int          error_cnt = 0;
  int          check_count = 0;
  int          seed = 32'h6547_7c2c;
  int          n;

  fft_peripheral_host_port DUT (
    .clk_i(clk_i), .rst_i(rst_i), .data_i(bus_level), .data_o(dev_data),
    .data_oe_n_o(dev_oe_n), .func_sel_i(func_sel), .bus_select_low_i(ie_n),
    .chip_sel_n_i(cs_n), .read_write_i(rw), .completion_request_n_o(req_n),
    .completion_request_oe_n_o(req_oe_n), .busy_o(busy));

  fft_host_model host (
    .clk_i(clk_i), .dev_data_i(dev_data), .dev_oe_n_i(dev_oe_n), .bus_o(bus_level),
    .func_o(func_sel), .ie_n_o(ie_n), .cs_n_o(cs_n), .rw_o(rw),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmd(input logic [3:0] func, input logic wr, input logic [7:0] data);
    host.access(func, wr, data, 2'b00);
  endtask

  task automatic put_word(input logic [15:0] w);
    cmd(fft_port_pkg::FUNC_LOWER, 1'b1, w[7:0]);
    cmd(fft_port_pkg::FUNC_UPPER, 1'b1, w[15:8]);
  endtask

  // Expectations go on the queue before the read so the monitor finds them in order.
  task automatic get_word(input logic [15:0] w);
    exp_q.push_back(w[7:0]);
    cmd(fft_port_pkg::FUNC_LOWER, 1'b0, 8'h00);
    exp_q.push_back(w[15:8]);
    cmd(fft_port_pkg::FUNC_UPPER, 1'b0, 8'h00);
  endtask

  task automatic wait_done(input int limit);
    n = 0;
    while (req_oe_n !== 1'b0 && n < limit)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask

  always @(posedge clk_i)
  begin
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() > 0)
        check("read_byte", {8'h00, exp_q.pop_front()}, {8'h00, rd_data});
      else
        check("read_byte", 16'h0000, 16'hxxxx);
    end
  end

  initial
  begin
    #200000;
    error_cnt++;
    $display("MISMATCH watchdog expected done seen hang");
    results();
  end

  initial
  begin
    rst_i = 1'b1;
    entries = '{fft_port_pkg::ENTRY_THIRTY_TWO_POINT_TRANSFORM, fft_port_pkg::ENTRY_COMBINE,
                fft_port_pkg::ENTRY_SCALE, fft_port_pkg::ENTRY_WINDOW,
                fft_port_pkg::ENTRY_CONJUGATION_ROUTINE};
    repeat (20) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    check("req_oe_n", 16'h0001, 16'(req_oe_n));
    check("busy", 16'h0000, 16'(busy));
    check("data_oe_n", 16'h00FF, 16'(dev_oe_n));
    // Fill the whole RAM, then one upper-only word that must land at 0.0 again.
    cmd(fft_port_pkg::FUNC_CHIP_RESET, 1'b1, 8'($random(seed)));
    cmd(fft_port_pkg::FUNC_BLOCK, 1'b1, 8'($random(seed)));
    for (int i = 0; i < 128; i++)
    begin
      mem[i] = 16'($random(seed));
      put_word(mem[i]);
    end
    mem[0] = {8'($random(seed)), 8'h00};
    cmd(fft_port_pkg::FUNC_UPPER, 1'b1, mem[0][15:8]);
    cmd(fft_port_pkg::FUNC_CHIP_RESET, 1'b0, 8'h00);
    cmd(fft_port_pkg::FUNC_BLOCK, 1'b0, 8'h00);
    for (int i = 0; i < 129; i++)
      get_word(mem[i % 128]);
    // Preset the index to base 3, column 1 through the setup routine.
    cmd(fft_port_pkg::FUNC_CHIP_RESET, 1'b1, 8'h00);
    cmd(fft_port_pkg::FUNC_UPPER, 1'b1, 8'h19);
    cmd(fft_port_pkg::FUNC_EXECUTE, 1'b1, fft_port_pkg::ENTRY_SETUP);
    repeat (20) @(posedge clk_i);
    check("req_oe_n", 16'h0001, 16'(req_oe_n));
    cmd(fft_port_pkg::FUNC_BLOCK, 1'b0, 8'h00);
    get_word(mem[35]);
    cmd(fft_port_pkg::FUNC_CHIP_RESET, 1'b1, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      cmd(fft_port_pkg::FUNC_EXECUTE, 1'b1, entries[i]);
      check("busy", 16'h0001, 16'(busy));
      check("req_oe_n", 16'h0001, 16'(req_oe_n));
      wait_done(fft_port_pkg::ROUTINE_CYCLES + 8);
      check("req_oe_n", 16'h0000, 16'(req_oe_n));
      check("req_n", 16'h0000, 16'(req_n));
      get_word(mem[0]);
    end
    cmd(fft_port_pkg::FUNC_CHIP_RESET, 1'b0, 8'h00);
    check("req_oe_n", 16'h0001, 16'(req_oe_n));
    host.access(fft_port_pkg::FUNC_EXECUTE, 1'b1, fft_port_pkg::ENTRY_THIRTY_TWO_POINT_TRANSFORM, 2'b10);
    host.access(fft_port_pkg::FUNC_EXECUTE, 1'b1, fft_port_pkg::ENTRY_THIRTY_TWO_POINT_TRANSFORM, 2'b01);
    check("busy", 16'h0000, 16'(busy));
    cmd(fft_port_pkg::FUNC_EXECUTE, 1'b1, 8'h55);
    wait_done(fft_port_pkg::ROUTINE_CYCLES + 8);
    check("req_oe_n", 16'h0001, 16'(req_oe_n));
    // A reset in mid-routine must cancel it without a request.
    cmd(fft_port_pkg::FUNC_EXECUTE, 1'b1, fft_port_pkg::ENTRY_CONJUGATION_ROUTINE);
    repeat (10) @(posedge clk_i);
    #1;
    rst_i = 1'b1;
    repeat (38) @(posedge clk_i);
    #1;
    check("busy", 16'h0000, 16'(busy));
    check("data_oe_n", 16'h00FF, 16'(dev_oe_n));
    rst_i = 1'b0;
    wait_done(fft_port_pkg::ROUTINE_CYCLES + 8);
    check("req_oe_n", 16'h0001, 16'(req_oe_n));
    check("queue_left", 16'h0000, 16'(exp_q.size()));
    results();
  end
endmodule
